// ==== tacl_pkg.sv ====
package tacl_pkg;
  // ---------------------------------------------------------------
  // Channel array geometry
  // ---------------------------------------------------------------
  localparam int TACL_NCH = 8;
  localparam int TACL_CW = 16;
  localparam int TACL_HW = 8;
  localparam int TACL_NPRE = 4;
  localparam int TACL_DIVW = 4;
  localparam int TACL_PREW = 15;
  // Channels that may be split into two 8-bit halves
  localparam logic [7:0] TACL_SPLIT_OK = 8'h0A;
  localparam int TACL_SPLIT_CH_A = 1;
  localparam int TACL_SPLIT_CH_B = 3;
  // Operation clock sources that must not be used by a linked group
  localparam logic [1:0] TACL_SRC_THIRD = 2'h2;
  localparam logic [1:0] TACL_SRC_FOURTH = 2'h3;
  // ---------------------------------------------------------------
  // Mode encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] TACL_MODE_INTERVAL = 2'h0;
  localparam logic [1:0] TACL_MODE_EVENT = 2'h1;
  localparam logic [1:0] TACL_MODE_DELAY = 2'h2;
  localparam logic [1:0] TACL_MODE_ONESHOT = 2'h3;
  // ---------------------------------------------------------------
  // Reset values and the count a one-shot loads when it stops
  // ---------------------------------------------------------------
  localparam logic [15:0] TACL_CNT_RST = 16'h0000;
  localparam logic [15:0] TACL_CNT_STOP = 16'hFFFF;
  localparam logic [14:0] TACL_PRE_RST = 15'h0000;
  // Noise filter needs this many equal operation-clock samples
  localparam int TACL_NF_SAMPLES = 2;

  typedef logic [TACL_NCH-1:0] tacl_chmask_t;
  typedef logic [1:0] tacl_sel_t;
endpackage : tacl_pkg

// ==== tacl_edge_if.sv ====
`timescale 1ns/10ps
interface tacl_edge_if;
  logic [7:0] op_tick;
  logic [7:0] edge_pulse;
  modport src (output op_tick, input edge_pulse);
  modport det (input op_tick, output edge_pulse);
endinterface : tacl_edge_if

// ==== tacl_edge_det.sv ====
`timescale 1ns/10ps
module tacl_edge_det
  import tacl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  // Timer inputs and filter enables
  input wire logic [TACL_NCH-1:0] timer_in,
  input wire logic [TACL_NCH-1:0] nf_en_in,
  // Towards the channel logic
  tacl_edge_if.det eif
);
  import tacl_pkg::*;

  genvar g;
  generate
    for (g = 0; g < TACL_NCH; g++) begin : g_ch
      logic s1_q, s2_q, s3_q;
      logic smp_q, filt_q, filt_d, prev_q;
      // Three stages; a change counts once stages two and three agree
      always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else if (clk_en_in) begin
          s1_q <= timer_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // Sampled on the operation clock tick; filter wants two equal samples
      always_comb begin
        filt_d = filt_q;
        if (!nf_en_in[g]) begin
          filt_d = smp_q;
        end else if (smp_q == s3_q) begin
          filt_d = smp_q;
        end
      end
      always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          smp_q <= 1'b0;
          filt_q <= 1'b0;
          prev_q <= 1'b0;
        end else if (clk_en_in && eif.op_tick[g] && (s2_q == s3_q)) begin
          smp_q <= s3_q;
          filt_q <= filt_d;
          prev_q <= filt_q;
        end
      end
      // One-cycle pulse on the sampled rising edge
      always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          eif.edge_pulse[g] <= 1'b0;
        end else if (clk_en_in) begin
          eif.edge_pulse[g] <= eif.op_tick[g] && filt_q && !prev_q;
        end
      end
    end
  endgenerate
endmodule : tacl_edge_det

// ==== tacl_core.sv ====
`timescale 1ns/10ps
// Contract
// - Only even channels may be masters.
// - Channel 0 is never a slave; slaves sit above their master.
// - One master may lead several slaves.
// - A slave follows only the nearest master below it.
// - Masters forward irq, start and count clock upward; slaves never forward. The code forwards start, stop and count clock, but not irq.
// - A master never takes signals from a lower master.
// - Channel 0 has no master bit yet always acts as master.
// - Linking constraints hold inside one group only.
// - Only channels 1 and 3 split, by their split select bit.
// - Upper half is interval only and interrupts at start.
// - Upper half uses the lower half's clock select.
// - Split halves have their own start, stop and status bits.
// - Lower half supports interval, event count and delay count.
// - Unsplit, upper start and stop do nothing; upper status holds.
// - Split channels cannot join linked one-shot or PWM groups.
// - Count clock is divided operation tick or input edge.
// - Input edge mode waits for a sampled rising edge.
// - Noise filter wants two equal operation-clock samples.
module tacl_core
  import tacl_pkg::*;
(
  // Clock, reset and enable
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  // Prescaler: divisor exponent per source
  input wire logic [TACL_NPRE*TACL_DIVW-1:0] prescaler_select_reg_in,
  // Per-channel configuration
  input wire logic [TACL_NCH*2-1:0] op_clock_sel_in,
  input wire tacl_pkg::tacl_chmask_t count_clock_source_in,
  input wire tacl_pkg::tacl_chmask_t master_sel_in,
  input wire tacl_pkg::tacl_chmask_t slave_link_in,
  input wire tacl_pkg::tacl_chmask_t split_8bit_select_in,
  input wire tacl_pkg::tacl_chmask_t start_irq_option_in,
  input wire tacl_pkg::tacl_chmask_t nf_en_in,
  input wire logic [TACL_NCH*2-1:0] mode_in,
  input wire logic [TACL_NCH*TACL_CW-1:0] reload_in,
  // Triggers
  input wire tacl_pkg::tacl_chmask_t chan_start_trigger_in,
  input wire tacl_pkg::tacl_chmask_t chan_stop_trigger_in,
  input wire logic upper_half_start_ch1_in,
  input wire logic upper_half_start_ch3_in,
  input wire logic upper_half_stop_ch1_in,
  input wire logic upper_half_stop_ch3_in,
  // Timer pins
  input wire tacl_pkg::tacl_chmask_t timer_in,
  // Status and events
  output tacl_pkg::tacl_chmask_t chan_enabled_status_out,
  output logic upper_half_status_ch1_out,
  output logic upper_half_status_ch3_out,
  output tacl_pkg::tacl_chmask_t channel_irq_out,
  output logic upper_half_irq_ch1_out,
  output logic upper_half_irq_ch3_out,
  output tacl_pkg::tacl_chmask_t is_master_out,
  output tacl_pkg::tacl_chmask_t link_error_out,
  output logic [TACL_NCH*TACL_CW-1:0] count_value_reg_out
);
  import tacl_pkg::*;

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  logic [TACL_PREW-1:0] pre_q;
  logic [TACL_NPRE-1:0] src_tick;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_q <= TACL_PRE_RST;
    end else if (clk_en_in) begin
      pre_q <= pre_q + 15'h0001;
    end
  end

  // A divided source is high for one clock when the low bits wrap
  genvar p;
  generate
    for (p = 0; p < TACL_NPRE; p++) begin : g_pre
      logic [3:0] ex;
      logic [15:0] msk;
      assign ex = prescaler_select_reg_in[p*TACL_DIVW +: TACL_DIVW];
      assign msk = (16'h0001 << ex) - 16'h0001;
      assign src_tick[p] = (({1'b0, pre_q} & msk) == msk);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Group structure
  // ---------------------------------------------------------------
  tacl_chmask_t master_eff;
  logic [2:0] lead [TACL_NCH];
  tacl_chmask_t linked;
  tacl_chmask_t link_err;

  // Channel 0 always leads; odd channels never do
  always_comb begin
    master_eff = master_sel_in & 8'h54;
    master_eff[0] = 1'b1;
  end

  // Each channel's leader is the nearest master at or below it
  always_comb begin
    for (int i = 0; i < TACL_NCH; i++) begin
      lead[i] = 3'h0;
      for (int j = 0; j <= i; j++) begin
        if (master_eff[j]) begin
          lead[i] = 3'(j);
        end
      end
    end
  end

  // A slave is linked only if it is not itself a master and not split
  always_comb begin
    for (int i = 0; i < TACL_NCH; i++) begin
      linked[i] = slave_link_in[i] && !master_eff[i] && (i != 0) &&
        !(split_8bit_select_in[i] && TACL_SPLIT_OK[i]);
      link_err[i] = 1'b0;
      if (linked[i]) begin
        if (op_clock_sel_in[2*i +: 2] != op_clock_sel_in[2*lead[i] +: 2]) begin
          link_err[i] = 1'b1;
        end
        if (op_clock_sel_in[2*i +: 2] == TACL_SRC_THIRD ||
            op_clock_sel_in[2*i +: 2] == TACL_SRC_FOURTH) begin
          link_err[i] = 1'b1;
        end
      end
    end
  end

  assign is_master_out = master_eff;
  assign link_error_out = link_err;

  // ---------------------------------------------------------------
  // Count clock formation
  // ---------------------------------------------------------------
  tacl_edge_if eif ();
  tacl_chmask_t own_tick;
  tacl_chmask_t own_cclk;
  tacl_chmask_t cclk;
  tacl_chmask_t strt;
  tacl_chmask_t stop;
  tacl_chmask_t irq_q;

  always_comb begin
    for (int i = 0; i < TACL_NCH; i++) begin
      own_tick[i] = src_tick[op_clock_sel_in[2*i +: 2]];
    end
  end
  assign eif.op_tick = own_tick;

  tacl_edge_det u_edge (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .clk_en_in(clk_en_in),
    .timer_in(timer_in),
    .nf_en_in(nf_en_in),
    .eif(eif)
  );

  // Slaves take the leader's count clock and triggers; leaders use their own
  always_comb begin
    for (int i = 0; i < TACL_NCH; i++) begin
      own_cclk[i] = count_clock_source_in[i] ? eif.edge_pulse[i] : own_tick[i];
    end
    for (int i = 0; i < TACL_NCH; i++) begin
      cclk[i] = linked[i] ? own_cclk[lead[i]] : own_cclk[i];
      strt[i] = chan_start_trigger_in[i] |
        (linked[i] & chan_start_trigger_in[lead[i]]);
      stop[i] = chan_stop_trigger_in[i] |
        (linked[i] & chan_stop_trigger_in[lead[i]]);
    end
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  tacl_chmask_t en_q;
  tacl_chmask_t wait_q;
  tacl_chmask_t split_act;
  logic [TACL_CW-1:0] cnt_q [TACL_NCH];

  assign split_act = split_8bit_select_in & TACL_SPLIT_OK;

  genvar c;
  generate
    for (c = 0; c < TACL_NCH; c++) begin : g_ch
      logic [1:0] md;
      logic [TACL_CW-1:0] rl;
      logic sp;
      logic [TACL_HW-1:0] lo;
      logic lo_zero;
      logic fire;
      logic cnt_ev;
      assign md = mode_in[2*c +: 2];
      assign rl = reload_in[c*TACL_CW +: TACL_CW];
      assign sp = split_act[c];
      assign lo = cnt_q[c][TACL_HW-1:0];
      assign lo_zero = sp ? (lo == 8'h00) : (cnt_q[c] == TACL_CNT_RST);
      assign cnt_ev = en_q[c] && cclk[c];

      // Event counter loads at start; others wait for the first count clock
      always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          en_q[c] <= 1'b0;
          wait_q[c] <= 1'b0;
        end else if (clk_en_in) begin
          if (stop[c]) begin
            en_q[c] <= 1'b0;
            wait_q[c] <= 1'b0;
          end else if (strt[c]) begin
            en_q[c] <= 1'b1;
            wait_q[c] <= (md != TACL_MODE_EVENT);
          end else if (cnt_ev && wait_q[c]) begin
            wait_q[c] <= 1'b0;
          end else if (cnt_ev && lo_zero && md == TACL_MODE_ONESHOT && !sp) begin
            en_q[c] <= 1'b0;
          end
        end
      end

      // Split lower half only runs interval, event and delay count
      always_comb begin
        fire = 1'b0;
        if (cnt_ev) begin
          if (wait_q[c]) begin
            fire = start_irq_option_in[c];
          end else if (lo_zero) begin
            fire = !(sp && md == TACL_MODE_ONESHOT);
          end
        end
      end

      always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          cnt_q[c] <= TACL_CNT_RST;
          irq_q[c] <= 1'b0;
        end else if (clk_en_in) begin
          irq_q[c] <= fire;
          if (strt[c] && md == TACL_MODE_EVENT) begin
            cnt_q[c][TACL_HW-1:0] <= rl[TACL_HW-1:0];
            if (!sp) begin
              cnt_q[c][TACL_CW-1:TACL_HW] <= rl[TACL_CW-1:TACL_HW];
            end
          end else if (cnt_ev) begin
            if (sp) begin
              cnt_q[c][TACL_HW-1:0] <= (wait_q[c] || lo_zero) ? rl[TACL_HW-1:0]
                : lo - 8'h01;
            end else if (wait_q[c]) begin
              cnt_q[c] <= rl;
            end else if (lo_zero) begin
              cnt_q[c] <= (md == TACL_MODE_ONESHOT) ? TACL_CNT_STOP : rl;
            end else begin
              cnt_q[c] <= cnt_q[c] - 16'h0001;
            end
          end
        end
      end

      assign count_value_reg_out[c*TACL_CW +: TACL_CW] = cnt_q[c];
    end
  endgenerate

  assign chan_enabled_status_out = en_q;
  assign channel_irq_out = irq_q;

  // ---------------------------------------------------------------
  // Upper halves of the split channels
  // ---------------------------------------------------------------
  logic [1:0] hen_q;
  logic [1:0] hwait_q;
  logic [1:0] hirq_q;
  logic [TACL_HW-1:0] hcnt_q [2];
  logic [1:0] hstart;
  logic [1:0] hstop;
  logic [1:0] hsp;
  logic [1:0] htick;
  logic [TACL_HW-1:0] hrl [2];

  // Upper triggers count only while the channel is split
  assign hsp = {split_act[TACL_SPLIT_CH_B], split_act[TACL_SPLIT_CH_A]};
  assign hstart = {upper_half_start_ch3_in, upper_half_start_ch1_in} & hsp;
  assign hstop = {upper_half_stop_ch3_in, upper_half_stop_ch1_in} & hsp;
  assign htick = {own_tick[TACL_SPLIT_CH_B], own_tick[TACL_SPLIT_CH_A]};
  assign hrl[0] = reload_in[TACL_SPLIT_CH_A*TACL_CW+TACL_HW +: TACL_HW];
  assign hrl[1] = reload_in[TACL_SPLIT_CH_B*TACL_CW+TACL_HW +: TACL_HW];

  genvar h;
  generate
    for (h = 0; h < 2; h++) begin : g_hi
      always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          hen_q[h] <= 1'b0;
          hwait_q[h] <= 1'b0;
          hirq_q[h] <= 1'b0;
          hcnt_q[h] <= 8'h00;
        end else if (clk_en_in) begin
          hirq_q[h] <= 1'b0;
          if (hstop[h]) begin
            hen_q[h] <= 1'b0;
            hwait_q[h] <= 1'b0;
          end else if (hstart[h]) begin
            hen_q[h] <= 1'b1;
            hwait_q[h] <= 1'b1;
          end else if (hen_q[h] && htick[h] && hsp[h]) begin
            // Interval only: start always interrupts
            hirq_q[h] <= hwait_q[h] || (hcnt_q[h] == 8'h00);
            hwait_q[h] <= 1'b0;
            hcnt_q[h] <= (hwait_q[h] || hcnt_q[h] == 8'h00) ? hrl[h]
              : hcnt_q[h] - 8'h01;
          end
        end
      end
    end
  endgenerate

  // Upper count stays internal; only its status and interrupt leave the block
  logic count_value_reg_out_hi_dummy;
  always_comb begin
    count_value_reg_out_hi_dummy = 1'b0;
  end

  assign upper_half_status_ch1_out = hen_q[0];
  assign upper_half_status_ch3_out = hen_q[1];
  assign upper_half_irq_ch1_out = hirq_q[0];
  assign upper_half_irq_ch3_out = hirq_q[1];
endmodule : tacl_core

// ==== tacl_core_asserts.sv ====
`timescale 1ns/10ps
module tacl_core_asserts
  import tacl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  // Configuration and triggers
  input wire logic [15:0] prescaler_select_reg_in,
  input wire logic [15:0] op_clock_sel_in,
  input wire tacl_pkg::tacl_chmask_t master_sel_in,
  input wire tacl_pkg::tacl_chmask_t slave_link_in,
  input wire tacl_pkg::tacl_chmask_t split_8bit_select_in,
  input wire tacl_pkg::tacl_chmask_t chan_start_trigger_in,
  input wire tacl_pkg::tacl_chmask_t chan_stop_trigger_in,
  input wire logic upper_half_start_ch1_in,
  input wire logic upper_half_stop_ch1_in,
  // Status and events
  input wire tacl_pkg::tacl_chmask_t chan_enabled_status_out,
  input wire logic upper_half_status_ch1_out,
  input wire tacl_pkg::tacl_chmask_t channel_irq_out,
  input wire logic upper_half_irq_ch1_out,
  input wire tacl_pkg::tacl_chmask_t is_master_out,
  input wire tacl_pkg::tacl_chmask_t link_error_out
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  a_even_master_only: assert property (is_master_out[7:1] == {1'b0, master_sel_in[6],
    1'b0, master_sel_in[4], 1'b0, master_sel_in[2], 1'b0}) else $error("odd master seen");
  a_ch0_always_master: assert property (is_master_out[0]) else $error("ch0 not master");
  a_start_sets_status: assert property (clk_en_in |=>
    ((chan_enabled_status_out & $past(chan_start_trigger_in) & ~$past(chan_stop_trigger_in))
    == ($past(chan_start_trigger_in) & ~$past(chan_stop_trigger_in)))) else $error("no start");
  a_stop_clears_status: assert property (clk_en_in |=>
    (chan_enabled_status_out & $past(chan_stop_trigger_in)) == 8'h00) else $error("no stop");
  a_slave_follows_lead: assert property (clk_en_in && slave_link_in[1] &&
    chan_start_trigger_in[0] && !chan_stop_trigger_in[1] |=> chan_enabled_status_out[1])
    else $error("slave missed start");
  a_far_slave_blocked: assert property (clk_en_in && slave_link_in[5] && master_sel_in[4] &&
    chan_start_trigger_in[0] && chan_start_trigger_in[5:4] == 2'h0 &&
    !chan_enabled_status_out[5] |=> !chan_enabled_status_out[5]) else $error("far slave ran");
  a_master_not_led: assert property (clk_en_in && master_sel_in[4] &&
    chan_start_trigger_in[0] && !chan_start_trigger_in[4] && !chan_enabled_status_out[4]
    |=> !chan_enabled_status_out[4]) else $error("master took lower start");
  a_irq_single_cycle: assert property (channel_irq_out != 8'h00 |=>
    (channel_irq_out & $past(channel_irq_out)) == 8'h00) else $error("irq too wide");
  a_upper_unsplit_hold: assert property (!split_8bit_select_in[1] |=>
    $stable(upper_half_status_ch1_out)) else $error("upper status moved");
  a_upper_start_sets: assert property (clk_en_in && split_8bit_select_in[1] &&
    upper_half_start_ch1_in && !upper_half_stop_ch1_in |=> upper_half_status_ch1_out)
    else $error("upper did not start");
  a_upper_start_irq: assert property (clk_en_in && split_8bit_select_in[1] &&
    upper_half_start_ch1_in && !upper_half_status_ch1_out && op_clock_sel_in[3:2] == 2'h0 &&
    prescaler_select_reg_in[3:0] == 4'h0 |-> ##[1:6] upper_half_irq_ch1_out)
    else $error("no upper start irq");
  a_slave_sel_match: assert property (slave_link_in[1] &&
    op_clock_sel_in[3:2] != op_clock_sel_in[1:0] |-> link_error_out[1])
    else $error("mismatch not flagged");
  a_slave_src_banned: assert property (slave_link_in[1] && op_clock_sel_in[3]
    |-> link_error_out[1]) else $error("banned source not flagged");
endmodule : tacl_core_asserts

bind tacl_core tacl_core_asserts chk_u (.core_clk_in, .nrst_in, .clk_en_in,
  .prescaler_select_reg_in, .op_clock_sel_in, .master_sel_in, .slave_link_in,
  .split_8bit_select_in, .chan_start_trigger_in, .chan_stop_trigger_in,
  .upper_half_start_ch1_in, .upper_half_stop_ch1_in, .chan_enabled_status_out,
  .upper_half_status_ch1_out, .channel_irq_out, .upper_half_irq_ch1_out, .is_master_out,
  .link_error_out);

// ==== tacl_core_tb.sv ====
`timescale 1ns/10ps
module tacl_core_tb;
  import tacl_pkg::*;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic [15:0] prescaler_select_reg_in = 16'h0000;
  logic [15:0] op_clock_sel_in = 16'h0000;
  logic [15:0] mode_in = 16'h0000;
  logic [127:0] reload_in = {8{16'h0005}};
  tacl_chmask_t count_clock_source_in = 8'h00;
  tacl_chmask_t master_sel_in = 8'h00;
  tacl_chmask_t slave_link_in = 8'h00;
  tacl_chmask_t split_8bit_select_in = 8'h00;
  tacl_chmask_t start_irq_option_in = 8'h00;
  tacl_chmask_t nf_en_in = 8'h00;
  tacl_chmask_t chan_start_trigger_in = 8'h00;
  tacl_chmask_t chan_stop_trigger_in = 8'h00;
  tacl_chmask_t timer_in = 8'h00;
  logic us1 = 1'b0, us3 = 1'b0, ut1 = 1'b0, ut3 = 1'b0;
  tacl_chmask_t status, irq, is_master, link_err;
  logic ust1, ust3, uirq1, uirq3;
  logic [127:0] cnt;
  int errors = 0;
  int compares = 0;

  always #2 core_clk_in = ~core_clk_in;

  tacl_core dut_u (.core_clk_in, .nrst_in, .clk_en_in, .prescaler_select_reg_in,
    .op_clock_sel_in(op_clock_sel_in), .count_clock_source_in, .master_sel_in,
    .slave_link_in, .split_8bit_select_in, .start_irq_option_in, .nf_en_in, .mode_in,
    .reload_in, .chan_start_trigger_in, .chan_stop_trigger_in, .upper_half_start_ch1_in(us1),
    .upper_half_start_ch3_in(us3), .upper_half_stop_ch1_in(ut1), .upper_half_stop_ch3_in(ut3),
    .timer_in, .chan_enabled_status_out(status), .upper_half_status_ch1_out(ust1),
    .upper_half_status_ch3_out(ust3), .channel_irq_out(irq), .upper_half_irq_ch1_out(uirq1),
    .upper_half_irq_ch3_out(uirq3), .is_master_out(is_master), .link_error_out(link_err),
    .count_value_reg_out(cnt));

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : step

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk

  task automatic trig(input tacl_chmask_t s, input tacl_chmask_t t);
    chan_start_trigger_in = s;
    chan_stop_trigger_in = t;
    step(1);
    chan_start_trigger_in = 8'h00;
    chan_stop_trigger_in = 8'h00;
  endtask : trig

  // Index 8 waits on the ch1 upper half; gives up after 300 cycles
  task automatic wait_irq(input int sel, output int n);
    n = 0;
    do begin
      step(1);
      n++;
    end while (n < 300 && ((sel < 8) ? irq[sel] : uirq1) !== 1'b1);
  endtask : wait_irq

  task automatic end_sim();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    chk(status, 8'h00);
    chk({ust1, ust3}, 2'h0);
    chk(cnt, 128'h0);
    chk(is_master, 8'h01);
    master_sel_in = 8'hFF;
    #1;
    chk(is_master, 8'h55);
    master_sel_in = 8'h00;
    $display("test_reset done");
  endtask : test_reset

  task automatic test_interval();
    int n;
    prescaler_select_reg_in = 16'h0020;
    reload_in[15:0] = 16'h0003;
    start_irq_option_in = 8'h01;
    for (int s = 0; s < 2; s++) begin
      op_clock_sel_in[1:0] = s[1:0];
      trig(8'h01, 8'h00);
      chk(status[0], 1'b1);
      wait_irq(0, n);
      chk(n <= 8, 1'b1);
      wait_irq(0, n);
      wait_irq(0, n);
      chk(n, 4 << (2 * s));
      trig(8'h00, 8'h01);
      chk(status[0], 1'b0);
    end
    start_irq_option_in = 8'h00;
    op_clock_sel_in = 16'h0000;
    $display("test_interval done");
  endtask : test_interval

  task automatic test_group();
    master_sel_in = 8'h10;
    slave_link_in = 8'h2E;
    trig(8'h01, 8'h00);
    chk(status, 8'h0F);
    trig(8'h01, 8'h00);
    chk(status, 8'h0F);
    trig(8'h10, 8'h00);
    chk(status, 8'h3F);
    trig(8'h00, 8'h0F);
    chk(status, 8'h30);
    trig(8'h00, 8'h30);
    master_sel_in = 8'h14;
    trig(8'h01, 8'h00);
    chk(status, 8'h03);
    trig(8'h00, 8'h03);
    clk_en_in = 1'b0;
    trig(8'h01, 8'h00);
    chk(status, 8'h00);
    clk_en_in = 1'b1;
    slave_link_in = 8'h00;
    trig(8'h40, 8'h40);
    chk(status, 8'h00);
    master_sel_in = 8'h00;
    $display("test_group done");
  endtask : test_group

  task automatic link_case(input tacl_chmask_t sl, input logic [15:0] sel, input logic e);
    slave_link_in = sl;
    op_clock_sel_in = sel;
    #1;
    chk(link_err[1], e);
  endtask : link_case

  task automatic test_link();
    link_case(8'h02, 16'h0000, 1'b0);
    link_case(8'h02, 16'h0004, 1'b1);
    link_case(8'h02, 16'h000A, 1'b1);
    link_case(8'h00, 16'h000A, 1'b0);
    op_clock_sel_in = 16'h0000;
    step(1);
    $display("test_link done");
  endtask : test_link

  task automatic test_split();
    int n;
    us1 = 1'b1;
    step(1);
    us1 = 1'b0;
    chk(ust1, 1'b0);
    split_8bit_select_in = 8'h0A;
    reload_in[31:16] = 16'h0203;
    prescaler_select_reg_in = 16'h3000;
    us1 = 1'b1;
    us3 = 1'b1;
    step(1);
    us1 = 1'b0;
    us3 = 1'b0;
    chk({ust1, ust3, status[1]}, 3'h6);
    wait_irq(8, n);
    chk(n <= 4, 1'b1);
    chk(uirq3, 1'b1);
    op_clock_sel_in[3:2] = 2'h3;
    wait_irq(8, n);
    wait_irq(8, n);
    wait_irq(8, n);
    chk(n, 24);
    trig(8'h02, 8'h00);
    chk({ust1, status[1]}, 2'h3);
    split_8bit_select_in = 8'h00;
    ut1 = 1'b1;
    step(1);
    ut1 = 1'b0;
    chk(ust1, 1'b1);
    split_8bit_select_in = 8'h0A;
    ut1 = 1'b1;
    ut3 = 1'b1;
    trig(8'h00, 8'h02);
    ut1 = 1'b0;
    ut3 = 1'b0;
    chk({ust1, ust3, status[1]}, 3'h0);
    split_8bit_select_in = 8'h00;
    op_clock_sel_in = 16'h0000;
    $display("test_split done");
  endtask : test_split

  task automatic test_edge();
    count_clock_source_in = 8'h40;
    mode_in[13:12] = TACL_MODE_EVENT;
    reload_in[111:96] = 16'h0010;
    prescaler_select_reg_in = 16'h0000;
    trig(8'h40, 8'h00);
    step(3);
    chk(cnt[111:96], 16'h0010);
    timer_in[6] = 1'b1;
    step(10);
    chk(cnt[111:96], 16'h000F);
    timer_in[6] = 1'b0;
    step(10);
    chk(cnt[111:96], 16'h000F);
    nf_en_in[6] = 1'b1;
    timer_in[6] = 1'b1;
    step(1);
    timer_in[6] = 1'b0;
    step(10);
    chk(cnt[111:96], 16'h000F);
    timer_in[6] = 1'b1;
    step(10);
    chk(cnt[111:96], 16'h000E);
    trig(8'h00, 8'h40);
    $display("test_edge done");
  endtask : test_edge

  initial begin
    step(5);
    nrst_in = 1'b1;
    step(1);
    test_reset();
    test_interval();
    test_group();
    test_link();
    test_split();
    test_edge();
    end_sim();
  end

  // Whole run needs well under 1000 cycles
  initial begin
    #20000;
    errors++;
    end_sim();
  end
endmodule : tacl_core_tb
